// File: ilcmt_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - A cleared B1 receive enable forces every received B1 bit to one, otherwise B1 passes.
// RQ2 - A cleared B2 receive enable forces every received B2 bit to one, otherwise B2 passes.
// RQ3 - In S/T mode the M bit goes out once per twenty frames, or only once with single sync set.
// RQ4 - In Up mode with single sync set one zero T bit may be sent once at the T position.
// RQ5 - The source select takes frame bits from the bit register at zero or the D-channel at one.
// RQ6 - Line sync pulses are made in TE mode only, or in TE and NT mode with NT sync set.
// RQ7 - The test frequency bit picks 96 kHz (S/T) or 192 kHz (Up) at zero and 2 kHz at one.
// RQ8 - The test signal is only sent while the test enable of control register zero is set.
// RQ9 - The tristate bit switches the transmit output buffer off.
// RQ10 - The exchange bit swaps the polarity of the two transmit pins.
// RQ11 - In S/T mode the four low transmit bits are Q1..Q4 in TE mode or S1..S4 in NT mode.
// RQ12 - In Up mode the four low transmit bits are T1a, T1b, T2a, T2b.
// RQ13 - Transmit bit 6 is the Up S bit and software keeps it zero in S/T mode.
// RQ14 - Software writes zero to reserved transmit bits 5, 4 and 7.
// RQ15 - Software selects the line interface before writing the per-interface registers.
// RQ16 - The test signal alternates every bit at 96/192 kHz, or once per frame at 2 kHz.
// RQ17 - Each interface keeps its own copy and a write only touches the selected one.
module ilcmt_top #(
	parameter int NUM_IF = 2
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// Line timing strobes from the framer
	input wire logic [NUM_IF-1:0] bit_tick_i,
	input wire logic [NUM_IF-1:0] frame_tick_i,
	input wire logic [NUM_IF-1:0] superframe_tick_i,
	// Receive bearer data
	input wire logic [NUM_IF-1:0] rx_b1_i,
	input wire logic [NUM_IF-1:0] rx_b2_i,
	output logic [NUM_IF-1:0] rx_b1_o,
	output logic [NUM_IF-1:0] rx_b2_o,
	// Frame bit sources
	input wire logic [NUM_IF-1:0][ilcmt_pkg::ILCMT_QST_W:0] frame_bit_register_i,
	input wire logic [NUM_IF-1:0][ilcmt_pkg::ILCMT_QST_W:0] dchan_bits_i,
	output logic [NUM_IF-1:0][ilcmt_pkg::ILCMT_QST_W:0] frame_src_bits_o,
	output logic [NUM_IF-1:0][ilcmt_pkg::ILCMT_QST_W:0] frame_qst_bits_o,
	// Sync and framing marks
	output logic [NUM_IF-1:0] sync_pulse_en_o,
	output logic [NUM_IF-1:0] mf_mark_o,
	output logic [NUM_IF-1:0] t_zero_o,
	// Transmit line
	input wire ilcmt_pkg::ilcmt_line_s [NUM_IF-1:0] tx_line_i,
	output ilcmt_pkg::ilcmt_line_s [NUM_IF-1:0] tx_line_o,
	output logic [NUM_IF-1:0] tx_oe_o,
	output logic [NUM_IF-1:0] test_freq_high_o
);
	import ilcmt_pkg::*;

	localparam int SELW = (NUM_IF > 1) ? $clog2(NUM_IF) : 1;

	// Elaboration check on the interface count
	if (NUM_IF < 1 || NUM_IF > 8) begin : gen_bad_num_if
		$error("NUM_IF must lie between 1 and 8");
	end

	ilcmt_bus_req_s req_r;
	logic [SELW-1:0] sel_r;
	ilcmt_ctrl_two_s ctrl2_r [NUM_IF];
	logic [7:0] mf_tx_r [NUM_IF];
	logic [7:0] ctrl0_r [NUM_IF];
	logic [7:0] ctrl3_r [NUM_IF];
	logic addr_ok;
	logic [SELW-1:0] wsel;

	// Address phase capture; only whole-word aligned transfers are decoded
	assign addr_ok = hsel_i && hready_i && htrans_i == ILCMT_HTRANS_NONSEQ
		&& hsize_i == ILCMT_HSIZE_WORD && haddr_i[1:0] == 2'b00
		&& haddr_i[31:10] == 22'h000000;
	assign wsel = hwdata_i[SELW-1:0];

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_r <= '0;
		end else if (hready_i) begin
			req_r.valid <= addr_ok;
			req_r.write <= hwrite_i;
			req_r.idx <= haddr_i[9:2];
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// Interface select; values beyond the last interface are ignored
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sel_r <= '0;
		end else if (req_r.valid && req_r.write && req_r.idx == ILCMT_IDX_SELECT
			&& 32'(hwdata_i[7:0]) < 32'(NUM_IF)) begin
			sel_r <= wsel;
		end
	end

	// Read data prepared in the address phase, shown in the data phase
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hrdata_o <= '0;
		end else if (hready_i) begin
			hrdata_o <= '0;
			if (addr_ok && !hwrite_i) begin
				unique case (haddr_i[9:2])
					ILCMT_IDX_SELECT: hrdata_o <= 32'(sel_r);
					ILCMT_IDX_STATUS: hrdata_o <= {24'h000000, tx_oe_o[sel_r],
						sync_pulse_en_o[sel_r], test_freq_high_o[sel_r],
						ctrl0_r[sel_r][ILCMT_POS_TEST_SIG],
						ctrl3_r[sel_r][ILCMT_POS_UP_MODE], 3'(sel_r)};
					default: hrdata_o <= '0;
				endcase
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_IF; g++) begin : gen_if
			logic wr_here;
			logic up_mode;
			logic nt_mode;
			logic test_on;
			logic [4:0] mf_cnt_r;
			logic single_armed_r;
			logic test_pol_r;
			logic test_mark_r;
			logic mark_evt;

			assign wr_here = req_r.valid && req_r.write && sel_r == SELW'(g); // [RQ17]
			assign up_mode = ctrl3_r[g][ILCMT_POS_UP_MODE];
			assign nt_mode = ctrl3_r[g][ILCMT_POS_NT_MODE];
			assign test_on = ctrl0_r[g][ILCMT_POS_TEST_SIG]; // [RQ8]

			// Per-interface register copies
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					ctrl2_r[g] <= ILCMT_RST_CTRL_TWO;
					mf_tx_r[g] <= ILCMT_RST_MF_TX;
					ctrl0_r[g] <= ILCMT_RST_CTRL_ZERO;
					ctrl3_r[g] <= ILCMT_RST_CTRL_THREE;
				end else if (wr_here) begin
					unique case (req_r.idx)
						ILCMT_IDX_CTRL_TWO: ctrl2_r[g] <= hwdata_i[7:0]; // [RQ17]
						ILCMT_IDX_MF_TX: mf_tx_r[g] <= hwdata_i[7:0]; // [RQ17]
						ILCMT_IDX_CTRL_ZERO: ctrl0_r[g] <= hwdata_i[7:0];
						ILCMT_IDX_CTRL_THREE: ctrl3_r[g] <= hwdata_i[7:0];
						default: ctrl2_r[g] <= ctrl2_r[g];
					endcase
				end
			end

			// Receive bearer masking
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					rx_b1_o[g] <= 1'b1;
					rx_b2_o[g] <= 1'b1;
				end else begin
					rx_b1_o[g] <= rx_b1_i[g] | ~ctrl2_r[g].first_bearer_receive_enable; // [RQ1]
					rx_b2_o[g] <= rx_b2_i[g] | ~ctrl2_r[g].second_bearer_receive_enable; // [RQ2]
				end
			end

			// Frame bits: S bit on top, Q/S or T bits below; S bit dropped in S/T mode
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					frame_src_bits_o[g] <= '0;
					frame_qst_bits_o[g] <= '0;
				end else begin
					frame_src_bits_o[g] <= ctrl2_r[g].frame_bit_source_select ?
						dchan_bits_i[g] : frame_bit_register_i[g]; // [RQ5]
					frame_qst_bits_o[g] <= {mf_tx_r[g][ILCMT_POS_SBIT] & up_mode, // [RQ13]
						mf_tx_r[g][ILCMT_QST_W-1:0]}; // [RQ11] [RQ12]
				end
			end

			// Multiframe counter over S/T frames
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					mf_cnt_r <= '0;
				end else if (frame_tick_i[g]) begin
					mf_cnt_r <= (mf_cnt_r == ILCMT_MF_LAST) ? 5'd0 : mf_cnt_r + 5'd1;
				end
			end

			assign mark_evt = up_mode ? superframe_tick_i[g]
				: (frame_tick_i[g] && mf_cnt_r == 5'd0);

			// Single-sync re-arms whenever software clears the select bit
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					single_armed_r <= 1'b1;
					mf_mark_o[g] <= 1'b0;
					t_zero_o[g] <= 1'b0;
				end else begin
					mf_mark_o[g] <= mark_evt &&
						(!ctrl2_r[g].single_sync_pulse_select || single_armed_r); // [RQ3]
					t_zero_o[g] <= up_mode && mark_evt &&
						ctrl2_r[g].single_sync_pulse_select && single_armed_r; // [RQ4]
					if (!ctrl2_r[g].single_sync_pulse_select) begin
						single_armed_r <= 1'b1;
					end else if (mark_evt) begin
						single_armed_r <= 1'b0; // [RQ3] [RQ4]
					end
				end
			end

			// Line sync pulses
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					sync_pulse_en_o[g] <= 1'b0;
				end else begin
					sync_pulse_en_o[g] <= !nt_mode || ctrl2_r[g].nt_sync_pulse_enable; // [RQ6]
				end
			end

			// Test signal: marks of alternating polarity, every bit or once per frame
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					test_pol_r <= 1'b0;
					test_mark_r <= 1'b0;
					test_freq_high_o[g] <= 1'b0;
				end else begin
					test_freq_high_o[g] <= test_on
						&& !ctrl2_r[g].low_test_frequency_select; // [RQ7]
					if (!test_on) begin
						test_mark_r <= 1'b0;
					end else if (ctrl2_r[g].low_test_frequency_select ? frame_tick_i[g]
						: bit_tick_i[g]) begin
						test_mark_r <= 1'b1; // [RQ16]
						test_pol_r <= ~test_pol_r; // [RQ16]
					end else if (ctrl2_r[g].low_test_frequency_select && bit_tick_i[g]) begin
						test_mark_r <= 1'b0; // [RQ16]
					end
				end
			end

			// Transmit pins: test override, swap, tristate
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					tx_line_o[g] <= '0;
					tx_oe_o[g] <= 1'b1;
				end else begin
					tx_oe_o[g] <= !ctrl2_r[g].output_tristate; // [RQ9]
					if (test_on) begin
						tx_line_o[g].p <= test_mark_r && (test_pol_r ^
							ctrl2_r[g].transmit_pin_swap); // [RQ8] [RQ10]
						tx_line_o[g].n <= test_mark_r && !(test_pol_r ^
							ctrl2_r[g].transmit_pin_swap); // [RQ8] [RQ10]
					end else if (ctrl2_r[g].transmit_pin_swap) begin
						tx_line_o[g] <= {tx_line_i[g].n, tx_line_i[g].p}; // [RQ10]
					end else begin
						tx_line_o[g] <= tx_line_i[g];
					end
				end
			end
		end
	endgenerate
endmodule

// File: ilcmt_pkg.sv
package ilcmt_pkg;
	// Registers are word indexes; byte address is four times the index
	localparam logic [7:0] ILCMT_IDX_SELECT = 8'h10;
	localparam logic [7:0] ILCMT_IDX_CTRL_ZERO = 8'h31;
	localparam logic [7:0] ILCMT_IDX_CTRL_TWO = 8'h33;
	localparam logic [7:0] ILCMT_IDX_MF_TX = 8'h34;
	localparam logic [7:0] ILCMT_IDX_CTRL_THREE = 8'h35;
	localparam logic [7:0] ILCMT_IDX_STATUS = 8'h3f;
	localparam logic [7:0] ILCMT_RST_CTRL_TWO = 8'h00;
	localparam logic [7:0] ILCMT_RST_MF_TX = 8'h00;
	localparam logic [7:0] ILCMT_RST_CTRL_ZERO = 8'h00;
	localparam logic [7:0] ILCMT_RST_CTRL_THREE = 8'h00;
	// Field positions
	localparam int ILCMT_POS_TEST_SIG = 5;
	localparam int ILCMT_POS_UP_MODE = 0;
	localparam int ILCMT_POS_NT_MODE = 2;
	localparam int ILCMT_POS_SBIT = 6;
	localparam int ILCMT_QST_W = 4;
	// Last frame index of the S/T multiframe of 20 frames
	localparam logic [4:0] ILCMT_MF_LAST = 5'd19;
	// AHB-Lite encodings
	localparam logic [1:0] ILCMT_HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] ILCMT_HSIZE_WORD = 3'b010;

	typedef struct packed {
		logic transmit_pin_swap;
		logic output_tristate;
		logic low_test_frequency_select;
		logic nt_sync_pulse_enable;
		logic frame_bit_source_select;
		logic single_sync_pulse_select;
		logic second_bearer_receive_enable;
		logic first_bearer_receive_enable;
	} ilcmt_ctrl_two_s;

	typedef struct packed {
		logic [7:0] idx;
		logic write;
		logic valid;
	} ilcmt_bus_req_s;

	typedef struct packed {
		logic p;
		logic n;
	} ilcmt_line_s;
endpackage

// File: ilcmt_monitor.sv
`timescale 1ns/1ps
module ilcmt_monitor #(
	parameter int NUM_IF = 2
) (
	// Clock, reset and bus
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	// Line side
	input wire logic [NUM_IF-1:0] frame_tick_i,
	input wire logic [NUM_IF-1:0] superframe_tick_i,
	input wire logic [NUM_IF-1:0] rx_b1_i,
	input wire logic [NUM_IF-1:0] rx_b2_i,
	input wire logic [NUM_IF-1:0] rx_b1_o,
	input wire logic [NUM_IF-1:0] rx_b2_o,
	input wire logic [NUM_IF-1:0][ilcmt_pkg::ILCMT_QST_W:0] frame_bit_register_i,
	input wire logic [NUM_IF-1:0][ilcmt_pkg::ILCMT_QST_W:0] dchan_bits_i,
	input wire logic [NUM_IF-1:0][ilcmt_pkg::ILCMT_QST_W:0] frame_src_bits_o,
	input wire logic [NUM_IF-1:0] sync_pulse_en_o,
	input wire logic [NUM_IF-1:0] mf_mark_o,
	input wire logic [NUM_IF-1:0] t_zero_o,
	input wire logic [NUM_IF-1:0] tx_oe_o
);
	import ilcmt_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	a_b1_force: assert property (!rx_b1_o[0] |-> !$past(rx_b1_i[0]))
		else $error("b1 low without low input");
	a_b2_force: assert property (!rx_b2_o[0] |-> !$past(rx_b2_i[0]))
		else $error("b2 low without low input");
	a_src_pick: assert property ($past(nrst_i, 2) |-> frame_src_bits_o[0] ==
		$past(frame_bit_register_i[0]) || frame_src_bits_o[0] == $past(dchan_bits_i[0]))
		else $error("frame bits from no source");
	a_mark_cause: assert property (mf_mark_o[0] |->
		$past(frame_tick_i[0] | superframe_tick_i[0]))
		else $error("mark without frame tick");
	a_mark_pulse: assert property (mf_mark_o[0] |=> !mf_mark_o[0])
		else $error("mark longer than one cycle");
	a_tz_single: assert property (t_zero_o[0] |=> !t_zero_o[0] [*8])
		else $error("zero T bit repeated");
	a_sync_cause: assert property ($past(nrst_i, 3) && $changed(sync_pulse_en_o) |->
		$past(htrans_i == ILCMT_HTRANS_NONSEQ && hwrite_i, 3))
		else $error("sync enable moved without write");
	a_oe_cause: assert property ($changed(tx_oe_o) |->
		$past(htrans_i == ILCMT_HTRANS_NONSEQ && hwrite_i, 3))
		else $error("output enable moved without write");
endmodule

bind ilcmt_top ilcmt_monitor #(.NUM_IF(NUM_IF)) u_mon (
	.sys_clk_i, .nrst_i, .htrans_i, .hwrite_i, .frame_tick_i, .superframe_tick_i,
	.rx_b1_i, .rx_b2_i, .rx_b1_o, .rx_b2_o, .frame_bit_register_i, .dchan_bits_i,
	.frame_src_bits_o, .sync_pulse_en_o, .mf_mark_o, .t_zero_o, .tx_oe_o
);

// File: ilcmt_line_model.sv
`timescale 1ns/1ps
module ilcmt_line_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Framer strobes, bearer data and bit sources
	output logic [1:0] bit_tick_o,
	output logic [1:0] frame_tick_o,
	output logic [1:0] sf_tick_o,
	output logic [1:0] rx_b1_o,
	output logic [1:0] rx_b2_o,
	output logic [1:0][4:0] fbr_o,
	output logic [1:0][4:0] dchan_o,
	output ilcmt_pkg::ilcmt_line_s [1:0] tx_line_o
);
	import ilcmt_pkg::*;
	logic [6:0] cnt_r;
	always_ff @(posedge sys_clk_i or negedge nrst_i)
		if (!nrst_i) cnt_r <= 7'h00;
		else cnt_r <= cnt_r + 7'h01;
	// Frame of 16 clocks, superframe of 8 frames
	assign bit_tick_o = {2{cnt_r[0]}};
	assign frame_tick_o = {2{cnt_r[3:0] == 4'hf}};
	assign sf_tick_o = {2{cnt_r == 7'h7f}};
	assign rx_b1_o = {2{cnt_r[1]}};
	assign rx_b2_o = {2{~cnt_r[2]}};
	assign fbr_o = {2{5'h0a}};
	assign dchan_o = {2{5'h15}};
	assign tx_line_o = {2{cnt_r[2], ~cnt_r[2]}};
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
	import ilcmt_pkg::*;
	logic sys_clk_i, nrst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
	logic [1:0] htrans_i, bit_tick_i, frame_tick_i, superframe_tick_i, rx_b1_i, rx_b2_i;
	logic [1:0] rx_b1_o, rx_b2_o, sync_pulse_en_o, mf_mark_o, t_zero_o, tx_oe_o;
	logic [1:0] test_freq_high_o, prev_rx;
	logic [2:0] hsize_i;
	logic [1:0][4:0] frame_bit_register_i, dchan_bits_i, frame_src_bits_o, frame_qst_bits_o;
	ilcmt_line_s [1:0] tx_line_i, tx_line_o;
	ilcmt_line_s prev_line;
	int fail_count, checks_done, marks, tzs, ps, ns;
	ilcmt_top i_ilcmt_top (
		.sys_clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
		.hready_i(hreadyout_o), .hwdata_i, .hreadyout_o, .hresp_o, .hrdata_o, .bit_tick_i,
		.frame_tick_i, .superframe_tick_i, .rx_b1_i, .rx_b2_i, .rx_b1_o, .rx_b2_o,
		.frame_bit_register_i, .dchan_bits_i, .frame_src_bits_o, .frame_qst_bits_o,
		.sync_pulse_en_o, .mf_mark_o, .t_zero_o, .tx_line_i, .tx_line_o, .tx_oe_o,
		.test_freq_high_o
	);
	ilcmt_line_model i_ilcmt_line_model (
		.sys_clk_i, .nrst_i, .bit_tick_o(bit_tick_i), .frame_tick_o(frame_tick_i),
		.sf_tick_o(superframe_tick_i), .rx_b1_o(rx_b1_i), .rx_b2_o(rx_b2_i),
		.fbr_o(frame_bit_register_i), .dchan_o(dchan_bits_i), .tx_line_o(tx_line_i)
	);
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		prev_rx <= {rx_b2_i[0], rx_b1_i[0]};
		prev_line <= tx_line_i[0];
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_ready(inout int n);
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 50);
	endtask
	task automatic bus(input logic [7:0] idx, input logic wr_en, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		haddr_i <= {22'h0, idx, 2'b00};
		htrans_i <= ILCMT_HTRANS_NONSEQ;
		hwrite_i <= wr_en;
		wait_ready(n);
		htrans_i <= 2'b00;
		hwdata_i <= {24'h0, d};
		wait_ready(n);
		rd = hrdata_o;
		if (n >= 50) fail_count++;
		if (n >= 50) close_out();
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask
	task automatic scan(input logic en);
		repeat (4) begin
			@(negedge sys_clk_i);
			chk({rx_b2_o[0], rx_b1_o[0], rx_b1_o[1]}, {prev_rx | {2{!en}}, 1'b1});
		end
	endtask
	task automatic count(input int cyc);
		marks = 0;
		tzs = 0;
		ps = 0;
		ns = 0;
		repeat (cyc) begin
			@(negedge sys_clk_i);
			marks += mf_mark_o[0];
			tzs += t_zero_o[0];
			ps += tx_line_o[0].p;
			ns += tx_line_o[0].n;
		end
	endtask
	initial begin
		fail_count = 0;
		checks_done = 0;
		nrst_i = 1'b0;
		hsel_i = 1'b1;
		hsize_i = ILCMT_HSIZE_WORD;
		haddr_i = 32'h0;
		htrans_i = 2'b00;
		hwrite_i = 1'b0;
		hwdata_i = 32'h0;
		repeat (20) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		bus(ILCMT_IDX_STATUS, 1'b0, 8'h00);
		chk(rd, 32'hc0);
		chk(hresp_o, 1'b0);
		bus(8'h20, 1'b0, 8'h00);
		chk(rd, 32'h0);
		wr(ILCMT_IDX_SELECT, 8'h00);
		scan(1'b0);
		wr(ILCMT_IDX_CTRL_TWO, 8'h03);
		scan(1'b1);
		$display("test bearer done");
		wr(ILCMT_IDX_CTRL_TWO, 8'h80);
		chk({tx_line_o[0], tx_oe_o}, {prev_line.n, prev_line.p, 2'b11});
		wr(ILCMT_IDX_CTRL_TWO, 8'h40);
		chk({tx_line_o[0], tx_oe_o}, {prev_line, 2'b10});
		for (int b = 0; b < 2; b++) begin
			wr(ILCMT_IDX_CTRL_TWO, 8'(b << 3));
			chk(frame_src_bits_o[0], b ? 5'h15 : 5'h0a);
		end
		$display("test line done");
		wr(ILCMT_IDX_CTRL_THREE, 8'h04);
		chk(sync_pulse_en_o[0], 1'b0);
		wr(ILCMT_IDX_CTRL_TWO, 8'h10);
		chk(sync_pulse_en_o[0], 1'b1);
		wr(ILCMT_IDX_CTRL_THREE, 8'h00);
		wr(ILCMT_IDX_CTRL_TWO, 8'h00);
		chk(test_freq_high_o[0], 1'b0);
		wr(ILCMT_IDX_CTRL_ZERO, 8'h20);
		chk(test_freq_high_o, 2'b01);
		count(8);
		count(64);
		chk(ps, 32);
		chk(ns, 32);
		wr(ILCMT_IDX_CTRL_TWO, 8'h20);
		chk(test_freq_high_o[0], 1'b0);
		count(8);
		count(64);
		chk(ps, 4);
		chk(ns, 4);
		wr(ILCMT_IDX_CTRL_ZERO, 8'h00);
		$display("test mode done");
		wr(ILCMT_IDX_MF_TX, 8'h05);
		chk(frame_qst_bits_o[0], 5'h05);
		wr(ILCMT_IDX_CTRL_THREE, 8'h01);
		wr(ILCMT_IDX_MF_TX, 8'h4a);
		chk(frame_qst_bits_o[0], 5'h1a);
		wr(ILCMT_IDX_MF_TX, 8'h0f);
		wr(ILCMT_IDX_CTRL_TWO, 8'h04);
		count(640);
		chk(tzs, 1);
		wr(ILCMT_IDX_CTRL_THREE, 8'h00);
		wr(ILCMT_IDX_CTRL_TWO, 8'h00);
		count(640);
		chk(marks, 2);
		wr(ILCMT_IDX_CTRL_TWO, 8'h04);
		count(640);
		chk(marks, 1);
		$display("test frame done");
		close_out();
	end
endmodule
